// ### verilog/t16_timer.sv
// 16-bit timer with compare, capture, PWM and an APB register port
//
// Contract
// - Outside PWM, match applies mode: 00 off, 01 toggle, 10 low, 11 high
// - Force bit applies pin action now, no flag, never clears counter
// - Force bits read zero; ignored in any PWM mode
// - Force written with new mode uses the old mode
// - PWM select: 00 off, 01 8-bit, 10 9-bit, 11 10-bit
// - Noise canceller needs four equal samples before capture
// - Without canceller, first sampled matching edge captures
// - Capture copies counter; edge select 0 falling, 1 rising
// - Clear-on-compare resets counter the cycle after match A
// - With prescaler, each value incl. compare and zero held one period
// - In PWM, clear-on-compare picks wrap, else up/down counting
// - Clock select: stop, /1, /8, /64, /256, /1024, ext fall, ext rise
// - External pin clocks counter even when pin is an output
// - 16-bit registers pass through one shared temporary byte
// - Up/down PWM sets overflow leaving zero; wrap PWM as normal
// - Interrupt needs flag, individual enable and global enable
// - Control B bits 5 and 4 always read zero
`timescale 1ns/1ns

module t16_timer #(
	parameter int FILT_LEN = 4
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        capture_pin,
	input  wire logic        ext_count_pin,
	output logic             compare_out_a_pin,
	output logic             compare_out_a_oe,
	output logic             compare_out_b_pin,
	output logic             compare_out_b_oe,
	output logic             irq
);

	// Filter length below two cannot qualify a level
	if (FILT_LEN < 2 || FILT_LEN > 16)
	begin
		$error("FILT_LEN out of range");
	end

	// Word-aligned register hit, used for every decode
	function automatic logic reg_hit(input logic [7:0] a,
		input logic [5:0] idx);
		reg_hit = (a[7:2] == idx) && (a[1:0] == 2'b00);
	endfunction

	// Non-PWM pin action on a match or force
	function automatic logic pin_act(input t16_pkg::t16_out_mode_t m,
		input logic cur);
		case (m)
			t16_pkg::OM_TOG: pin_act = ~cur;
			t16_pkg::OM_CLR: pin_act = 1'b0;
			t16_pkg::OM_SET: pin_act = 1'b1;
			default:         pin_act = cur;
		endcase
	endfunction

	// PWM pin action; mode bit 0 picks inverted output
	function automatic logic pwm_act(input t16_pkg::t16_out_mode_t m,
		input logic cur, input logic match, input logic wrap_ev,
		input logic down);
		if (!m[1])
			pwm_act = cur;
		else if (match)
			pwm_act = down ? ~m[0] : m[0];
		else if (wrap_ev)
			pwm_act = ~m[0];
		else
			pwm_act = cur;
	endfunction

	localparam int IRQ_W_L = t16_pkg::IRQ_W;

	t16_pkg::t16_ctrl_a_t ctrl_a;
	t16_pkg::t16_ctrl_b_t ctrl_b;
	t16_pkg::t16_dir_t    dir;
	t16_pkg::t16_dir_t    next_dir;
	logic [15:0]          cnt;
	logic [15:0]          next_cnt;
	logic [15:0]          cmp_a;
	logic [15:0]          cmp_b;
	logic [15:0]          cap_val;
	logic [15:0]          top;
	logic [7:0]           temp;
	logic [7:0]           snap_hi;
	logic [7:0]           next_snap_hi;
	logic [31:0]          rd_mux;
	logic [9:0]           pre;
	logic [IRQ_W_L-1:0]   irq_stat;
	logic [IRQ_W_L-1:0]   irq_mask;
	logic [IRQ_W_L-1:0]   irq_ev;
	logic                 irq_glob;
	logic                 tick;
	logic                 ovf_ev;
	logic                 wrap_ev;
	logic                 ext_s1;
	logic                 ext_s2;
	logic                 ext_s3;
	logic                 cap_s1;
	logic                 cap_s2;
	logic [FILT_LEN-1:0]  cap_hist;
	logic                 cap_lvl;
	logic                 next_cap_lvl;

	// Bus phase decode
	wire setup    = psel & ~penable;
	wire access   = psel & penable;
	wire wr       = access & pwrite;
	wire rd_acc   = access & ~pwrite;
	wire hit_ca   = reg_hit(paddr, t16_pkg::IDX_CTRL_A);
	wire hit_cb   = reg_hit(paddr, t16_pkg::IDX_CTRL_B);
	wire hit_cl   = reg_hit(paddr, t16_pkg::IDX_CNT_LO);
	wire hit_ch   = reg_hit(paddr, t16_pkg::IDX_CNT_HI);
	wire hit_al   = reg_hit(paddr, t16_pkg::IDX_CMPA_LO);
	wire hit_ah   = reg_hit(paddr, t16_pkg::IDX_CMPA_HI);
	wire hit_bl   = reg_hit(paddr, t16_pkg::IDX_CMPB_LO);
	wire hit_bh   = reg_hit(paddr, t16_pkg::IDX_CMPB_HI);
	wire hit_pl   = reg_hit(paddr, t16_pkg::IDX_CAP_LO);
	wire hit_ph   = reg_hit(paddr, t16_pkg::IDX_CAP_HI);
	wire hit_st   = reg_hit(paddr, t16_pkg::IDX_IRQ_STAT);
	wire hit_mk   = reg_hit(paddr, t16_pkg::IDX_IRQ_MASK);
	wire hit_gl   = reg_hit(paddr, t16_pkg::IDX_IRQ_GLOB);
	wire hit_lo   = hit_cl | hit_al | hit_bl | hit_pl;
	wire hit_hi   = hit_ch | hit_ah | hit_bh | hit_ph;
	wire mapped   = hit_ca | hit_cb | hit_lo | hit_hi | hit_st
		| hit_mk | hit_gl;

	// Register write strobes
	wire wr_ca    = wr & hit_ca;
	wire wr_cb    = wr & hit_cb;
	wire wr_cl    = wr & hit_cl;
	wire wr_al    = wr & hit_al;
	wire wr_bl    = wr & hit_bl;
	wire wr_hi    = wr & hit_hi & ~hit_ph;
	wire wr_st    = wr & hit_st;
	wire wr_mk    = wr & hit_mk;
	wire wr_gl    = wr & hit_gl;
	wire rd_lo    = rd_acc & hit_lo;
	wire [15:0] wr_word = {temp, pwdata[7:0]};

	// Mode decode
	wire pwm_on   = ctrl_a.pwm_sel != t16_pkg::PWM_OFF;
	wire ctc      = ctrl_b.clear_on_compare;
	wire force_a  = wr_ca & pwdata[t16_pkg::FORCE_A_BIT] & ~pwm_on;
	wire force_b  = wr_ca & pwdata[t16_pkg::FORCE_B_BIT] & ~pwm_on;
	wire match_a  = tick & (cnt == cmp_a);
	wire match_b  = tick & (cnt == cmp_b);
	wire ext_fall = ext_s3 & ~ext_s2;
	wire ext_rise = ~ext_s3 & ext_s2;
	wire down     = pwm_on & ~ctc & (dir == t16_pkg::DIR_DOWN);
	wire all_hi   = &cap_hist;
	wire all_lo   = ~|cap_hist;
	wire cap_ev   = (next_cap_lvl != cap_lvl)
		& (next_cap_lvl == ctrl_b.edge_sel);

	// APB answers: zero wait states, error on unmapped words
	assign pready = 1'b1;

	// Counter top for each PWM resolution
	always_comb
	begin
		case (ctrl_a.pwm_sel)
			t16_pkg::PWM_8:  top = t16_pkg::TOP8;
			t16_pkg::PWM_9:  top = t16_pkg::TOP9;
			t16_pkg::PWM_10: top = t16_pkg::TOP10;
			default:         top = t16_pkg::CNT_MAX;
		endcase
	end

	// Prescaler free-runs from the system clock, so all taps share it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre <= '0;
		else
			pre <= 10'(pre + 10'h001);
	end

	// Count enable from the clock select
	always_comb
	begin
		case (ctrl_b.clk_sel)
			t16_pkg::CS_DIV1: tick = 1'b1;
			t16_pkg::CS_DIV8: tick = (pre & t16_pkg::DIV8_M)
				== t16_pkg::DIV8_M;
			t16_pkg::CS_D64:  tick = (pre & t16_pkg::DIV64_M)
				== t16_pkg::DIV64_M;
			t16_pkg::CS_D256: tick = (pre & t16_pkg::DIV256_M)
				== t16_pkg::DIV256_M;
			t16_pkg::CS_D1K:  tick = pre == t16_pkg::DIV1024_M;
			t16_pkg::CS_EXTF: tick = ext_fall;
			t16_pkg::CS_EXTR: tick = ext_rise;
			default:          tick = 1'b0;
		endcase
	end

	// Pin synchronisers; the pin is read whatever its port direction
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			cap_s1 <= 1'b0;
			cap_s2 <= 1'b0;
		end
		else
		begin
			ext_s1 <= ext_count_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			cap_s1 <= capture_pin;
			cap_s2 <= cap_s1;
		end
	end

	// Counter next state; only advances on tick, so every value,
	// including the compare value and the zero after it, is held
	// for one prescaled period
	always_comb
	begin
		next_cnt = cnt;
		next_dir = dir;
		ovf_ev = 1'b0;
		wrap_ev = 1'b0;
		if (wr_cl)
			next_cnt = wr_word;
		else if (tick && !pwm_on)
		begin
			if (ctc && cnt == cmp_a)
				next_cnt = '0;
			else
			begin
				next_cnt = 16'(cnt + 16'h0001);
				ovf_ev = cnt == t16_pkg::CNT_MAX;
			end
		end
		else if (tick && ctc)
		begin
			if (cnt >= top)
			begin
				next_cnt = '0;
				ovf_ev = 1'b1;
				wrap_ev = 1'b1;
			end
			else
				next_cnt = 16'(cnt + 16'h0001);
		end
		else if (tick && dir == t16_pkg::DIR_UP)
		begin
			if (cnt >= top)
			begin
				next_dir = t16_pkg::DIR_DOWN;
				next_cnt = 16'(cnt - 16'h0001);
			end
			else
				next_cnt = 16'(cnt + 16'h0001);
		end
		else if (tick)
		begin
			if (cnt == '0)
			begin
				next_dir = t16_pkg::DIR_UP;
				next_cnt = 16'h0001;
				ovf_ev = 1'b1;
			end
			else
				next_cnt = 16'(cnt - 16'h0001);
		end
		if (!pwm_on || ctc)
			next_dir = t16_pkg::DIR_UP;
	end

	// Counter and direction
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= t16_pkg::WORD_RST;
			dir <= t16_pkg::DIR_UP;
		end
		else
		begin
			cnt <= next_cnt;
			dir <= next_dir;
		end
	end

	// Control registers; force bits are strobes and never stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_a <= t16_pkg::CTRL_RST;
			ctrl_b <= t16_pkg::CTRL_RST;
		end
		else
		begin
			if (wr_ca)
			begin
				ctrl_a <= pwdata[7:0];
				ctrl_a.force_a <= 1'b0;
				ctrl_a.force_b <= 1'b0;
			end
			if (wr_cb)
			begin
				ctrl_b <= pwdata[7:0];
				ctrl_b.rsvd <= 2'b00;
			end
		end
	end

	// Compare pins; actions use the mode held before this write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			compare_out_a_pin <= 1'b0;
			compare_out_b_pin <= 1'b0;
		end
		else if (pwm_on)
		begin
			compare_out_a_pin <= pwm_act(ctrl_a.mode_a,
				compare_out_a_pin, match_a, wrap_ev, down);
			compare_out_b_pin <= pwm_act(ctrl_a.mode_b,
				compare_out_b_pin, match_b, wrap_ev, down);
		end
		else
		begin
			if (match_a || force_a)
				compare_out_a_pin <= pin_act(ctrl_a.mode_a,
					compare_out_a_pin);
			if (match_b || force_b)
				compare_out_b_pin <= pin_act(ctrl_a.mode_b,
					compare_out_b_pin);
		end
	end

	// Pin drive enables; port direction outside still gates the pad
	assign compare_out_a_oe = pwm_on ? ctrl_a.mode_a[1]
		: ctrl_a.mode_a != t16_pkg::OM_OFF;
	assign compare_out_b_oe = pwm_on ? ctrl_a.mode_b[1]
		: ctrl_a.mode_b != t16_pkg::OM_OFF;

	// Capture level: filtered needs a run of equal samples
	assign next_cap_lvl = !ctrl_b.noise_cancel ? cap_s2
		: all_hi ? 1'b1 : all_lo ? 1'b0 : cap_lvl;

	// Capture history, qualified level and captured value
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cap_hist <= '0;
			cap_lvl <= 1'b0;
			cap_val <= t16_pkg::WORD_RST;
		end
		else
		begin
			cap_hist <= {cap_hist[FILT_LEN-2:0], cap_s2};
			cap_lvl <= next_cap_lvl;
			if (cap_ev)
				cap_val <= cnt;
		end
	end

	// Compare registers and the shared high byte
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp_a <= t16_pkg::WORD_RST;
			cmp_b <= t16_pkg::WORD_RST;
			temp <= '0;
		end
		else
		begin
			if (wr_al)
				cmp_a <= wr_word;
			if (wr_bl)
				cmp_b <= wr_word;
			if (wr_hi)
				temp <= pwdata[7:0];
			else if (rd_lo)
				temp <= snap_hi;
		end
	end

	// Events: force never reaches the compare flags
	assign irq_ev[t16_pkg::ST_OVF]  = ovf_ev;
	assign irq_ev[t16_pkg::ST_CMPA] = match_a;
	assign irq_ev[t16_pkg::ST_CMPB] = match_b;
	assign irq_ev[t16_pkg::ST_CAP]  = cap_ev;

	// Sticky status, write one to clear; a new event wins the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat <= t16_pkg::IRQ_RST;
			irq_mask <= t16_pkg::IRQ_RST;
			irq_glob <= 1'b0;
		end
		else
		begin
			irq_stat <= (irq_stat & ~(wr_st ? pwdata[IRQ_W_L-1:0]
				: t16_pkg::IRQ_RST)) | irq_ev;
			if (wr_mk)
				irq_mask <= pwdata[IRQ_W_L-1:0];
			if (wr_gl)
				irq_glob <= pwdata[0];
		end
	end

	// Interrupt needs flag, its enable and the global enable
	assign irq = irq_glob & |(irq_stat & irq_mask);

	// Read data select; high bytes always come from the shared byte
	always_comb
	begin
		rd_mux = '0;
		next_snap_hi = snap_hi;
		if (hit_ca)
			rd_mux[7:0] = {ctrl_a.mode_a, ctrl_a.mode_b,
				2'b00, ctrl_a.pwm_sel};
		if (hit_cb)
			rd_mux[7:0] = {ctrl_b.noise_cancel, ctrl_b.edge_sel,
				2'b00, ctrl_b.clear_on_compare,
				ctrl_b.clk_sel};
		if (hit_cl)
			{next_snap_hi, rd_mux[7:0]} = cnt;
		if (hit_al)
			{next_snap_hi, rd_mux[7:0]} = cmp_a;
		if (hit_bl)
			{next_snap_hi, rd_mux[7:0]} = cmp_b;
		if (hit_pl)
			{next_snap_hi, rd_mux[7:0]} = cap_val;
		if (hit_hi)
			rd_mux[7:0] = temp;
		if (hit_st)
			rd_mux[IRQ_W_L-1:0] = irq_stat;
		if (hit_mk)
			rd_mux[IRQ_W_L-1:0] = irq_mask;
		if (hit_gl)
			rd_mux[0] = irq_glob;
	end

	// Read data and error sampled in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= '0;
			pslverr <= 1'b0;
			snap_hi <= '0;
		end
		else if (setup)
		begin
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= ~mapped;
			snap_hi <= next_snap_hi;
		end
	end

endmodule

// ### verilog/t16_pkg.sv
// Constants, field layouts and types of the 16-bit timer block
package t16_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL_B   = 6'h2e;
	localparam logic [5:0] IDX_CTRL_A   = 6'h2f;
	localparam logic [5:0] IDX_CNT_LO   = 6'h30;
	localparam logic [5:0] IDX_CNT_HI   = 6'h31;
	localparam logic [5:0] IDX_CMPA_LO  = 6'h32;
	localparam logic [5:0] IDX_CMPA_HI  = 6'h33;
	localparam logic [5:0] IDX_CMPB_LO  = 6'h34;
	localparam logic [5:0] IDX_CMPB_HI  = 6'h35;
	localparam logic [5:0] IDX_CAP_LO   = 6'h36;
	localparam logic [5:0] IDX_CAP_HI   = 6'h37;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h38;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h39;
	localparam logic [5:0] IDX_IRQ_GLOB = 6'h3a;

	// Reset values
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [3:0]  IRQ_RST  = 4'h0;

	// Interrupt status / mask bit positions
	localparam int IRQ_W   = 4;
	localparam int ST_OVF  = 0;
	localparam int ST_CMPA = 1;
	localparam int ST_CMPB = 2;
	localparam int ST_CAP  = 3;

	// Force bit positions inside control A write data
	localparam int FORCE_A_BIT = 3;
	localparam int FORCE_B_BIT = 2;

	// Counter limits
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] TOP8    = 16'h00ff;
	localparam logic [15:0] TOP9    = 16'h01ff;
	localparam logic [15:0] TOP10   = 16'h03ff;

	// Prescaler terminal masks
	localparam int          PRE_W    = 10;
	localparam logic [9:0]  DIV8_M   = 10'h007;
	localparam logic [9:0]  DIV64_M  = 10'h03f;
	localparam logic [9:0]  DIV256_M = 10'h0ff;
	localparam logic [9:0]  DIV1024_M = 10'h3ff;

	typedef enum logic [1:0] {
		OM_OFF = 2'b00,
		OM_TOG = 2'b01,
		OM_CLR = 2'b10,
		OM_SET = 2'b11
	} t16_out_mode_t;

	typedef enum logic [1:0] {
		PWM_OFF = 2'b00,
		PWM_8   = 2'b01,
		PWM_9   = 2'b10,
		PWM_10  = 2'b11
	} t16_pwm_t;

	typedef enum logic [2:0] {
		CS_STOP = 3'b000,
		CS_DIV1 = 3'b001,
		CS_DIV8 = 3'b010,
		CS_D64  = 3'b011,
		CS_D256 = 3'b100,
		CS_D1K  = 3'b101,
		CS_EXTF = 3'b110,
		CS_EXTR = 3'b111
	} t16_clk_sel_t;

	typedef enum logic [0:0] {
		DIR_UP   = 1'b0,
		DIR_DOWN = 1'b1
	} t16_dir_t;

	// Control register A, bit 7 first
	typedef struct packed {
		t16_out_mode_t mode_a;
		t16_out_mode_t mode_b;
		logic          force_a;
		logic          force_b;
		t16_pwm_t      pwm_sel;
	} t16_ctrl_a_t;

	// Control register B, bit 7 first
	typedef struct packed {
		logic         noise_cancel;
		logic         edge_sel;
		logic [1:0]   rsvd;
		logic         clear_on_compare;
		t16_clk_sel_t clk_sel;
	} t16_ctrl_b_t;

endpackage

// ### testbench/t16_timer_sva.sv
// Port-level assertions for the 16-bit timer block
`timescale 1ns/1ns
module t16_timer_sva #(
	parameter int FILT_LEN = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        capture_pin,
	input wire logic        ext_count_pin,
	input wire logic        compare_out_a_pin,
	input wire logic        compare_out_a_oe,
	input wire logic        compare_out_b_pin,
	input wire logic        compare_out_b_oe,
	input wire logic        irq
);
	logic [7:0] sh_a;
	logic [7:0] sh_b;
	logic       wr_en;
	logic       rd_acc;
	logic       wr_a;

	// Completed transfers, decoded once
	assign wr_en  = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign wr_a   = wr_en && paddr[7:2] == t16_pkg::IDX_CTRL_A;

	// Shadow of both control registers, force bits kept as written
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sh_a <= 8'h00;
			sh_b <= 8'h00;
		end
		else if (wr_a)
			sh_a <= pwdata[7:0];
		else if (wr_en && paddr[7:2] == t16_pkg::IDX_CTRL_B)
			sh_b <= pwdata[7:0];
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_rd_ctrl_a;
		rd_acc && paddr[7:2] == t16_pkg::IDX_CTRL_A
			|-> prdata == {24'h0, sh_a[7:4], 2'b00, sh_a[1:0]};
	endproperty
	a_rd_ctrl_a: assert property (p_rd_ctrl_a)
		else $error("control A readback wrong");

	property p_rd_ctrl_b;
		rd_acc && paddr[7:2] == t16_pkg::IDX_CTRL_B
			|-> prdata == {24'h0, sh_b[7:6], 2'b00, sh_b[3:0]};
	endproperty
	a_rd_ctrl_b: assert property (p_rd_ctrl_b)
		else $error("control B readback wrong");

	property p_oe_off;
		sh_a[1:0] == 2'b00 && sh_a[7:6] == 2'b00 |-> !compare_out_a_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("pin A driven while disconnected");

	property p_oe_on;
		sh_a[1:0] == 2'b00 && sh_a[5:4] != 2'b00 |-> compare_out_b_oe;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("pin B not driven while connected");

	property p_pwm_oe;
		sh_a[1:0] != 2'b00 && sh_a[7] |-> compare_out_a_oe;
	endproperty
	a_pwm_oe: assert property (p_pwm_oe)
		else $error("pin A not driven in pwm mode");

	property p_force_lvl;
		wr_a && pwdata[3] && pwdata[1:0] == 2'b00 && sh_a[1:0] == 2'b00
			&& sh_a[7] && sh_b[2:0] == 3'b000
			|=> compare_out_a_pin == $past(sh_a[6]);
	endproperty
	a_force_lvl: assert property (p_force_lvl)
		else $error("forced level not from previous mode");

	property p_force_noflag;
		wr_a && (pwdata[3] || pwdata[2]) && sh_b[2:0] == 3'b000
			|=> !$rose(irq);
	endproperty
	a_force_noflag: assert property (p_force_noflag)
		else $error("force raised an interrupt");

	property p_irq_fall;
		$fell(irq) |-> $past(wr_en);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt dropped without a write");
endmodule

bind t16_timer t16_timer_sva #(.FILT_LEN(FILT_LEN)) u_sva (
	.pclk              (pclk),
	.presetn           (presetn),
	.psel              (psel),
	.penable           (penable),
	.pwrite            (pwrite),
	.paddr             (paddr),
	.pwdata            (pwdata),
	.prdata            (prdata),
	.pready            (pready),
	.pslverr           (pslverr),
	.capture_pin       (capture_pin),
	.ext_count_pin     (ext_count_pin),
	.compare_out_a_pin (compare_out_a_pin),
	.compare_out_a_oe  (compare_out_a_oe),
	.compare_out_b_pin (compare_out_b_pin),
	.compare_out_b_oe  (compare_out_b_oe),
	.irq               (irq)
);

// ### testbench/t16_pins.sv
// Model of the board signals feeding the capture and count pins
`timescale 1ns/1ns
module t16_pins (
	input  wire logic pclk,
	input  wire logic cap_lvl,
	input  wire logic ext_lvl,
	output logic      capture_pin,
	output logic      ext_count_pin
);
	// Launched just after the edge; the count pin has no direction gate
	always_ff @(posedge pclk)
	begin
		capture_pin   <= cap_lvl;
		ext_count_pin <= ext_lvl;
	end
endmodule

// ### testbench/test_timer16_compare_capture_pwm.sv
// Self-checking bench of the 16-bit timer block
`timescale 1ns/1ns
module test_timer16_compare_capture_pwm;
	localparam int CEIL = 90000;
	localparam int DIV [5] = '{1, 8, 64, 256, 1024};
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        cap_lvl = 1'b0;
	logic        ext_lvl = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cap_pin;
	logic        ext_pin;
	logic        pin_a;
	logic        oe_a;
	logic        pin_b;
	logic        oe_b;
	logic        irq;
	logic [31:0] q;
	logic        err;
	int          failures = 0;
	int          checked = 0;
	int          cyc = 0;

	t16_timer #(.FILT_LEN(4)) u_dut (
		.pclk (pclk), .presetn (presetn), .psel (psel),
		.penable (penable), .pwrite (pwrite), .paddr (paddr),
		.pwdata (pwdata), .prdata (prdata), .pready (pready),
		.pslverr (pslverr), .capture_pin (cap_pin),
		.ext_count_pin (ext_pin), .compare_out_a_pin (pin_a),
		.compare_out_a_oe (oe_a), .compare_out_b_pin (pin_b),
		.compare_out_b_oe (oe_b), .irq (irq)
	);

	t16_pins u_pins (
		.pclk (pclk), .cap_lvl (cap_lvl), .ext_lvl (ext_lvl),
		.capture_pin (cap_pin), .ext_count_pin (ext_pin)
	);

	// 20 MHz clock and a hang guard
	always #25 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc = cyc + 1;
		if (cyc == CEIL)
		begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; ends settled at the falling edge
	task automatic apb(input logic [5:0] idx, input logic wr,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask

	// Word access, high byte through the shared temporary first
	task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
		apb(lo + 6'h01, 1'b1, v[15:8]);
		apb(lo, 1'b1, v[7:0]);
	endtask

	task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
		apb(lo, 1'b0, 8'h00);
		v[7:0] = q[7:0];
		apb(lo + 6'h01, 1'b0, 8'h00);
		v[15:8] = q[7:0];
	endtask

	// Falling edges until pin A changes, bounded
	task automatic meas(output int n);
		logic p;
		p = pin_a;
		n = 0;
		while (pin_a === p && n < 20000)
		begin
			@(negedge pclk);
			n++;
		end
	endtask

	task automatic pulse(input int w, input logic ext);
		@(posedge pclk);
		if (ext)
			ext_lvl <= 1'b1;
		else
			cap_lvl <= 1'b1;
		repeat (w) @(posedge pclk);
		ext_lvl <= 1'b0;
		cap_lvl <= 1'b0;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
	endtask

	task automatic t_reset();
		apb(t16_pkg::IDX_CTRL_A, 1'b0, 8'h00);
		chk("ctrl_a reset", 32'h0, q);
		apb(t16_pkg::IDX_CTRL_B, 1'b0, 8'h00);
		chk("ctrl_b reset", 32'h0, q);
		apb(t16_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		chk("status reset", 32'h0, q);
		apb(6'h00, 1'b0, 8'h00);
		chk("unmapped err", 32'h1, {31'h0, err});
	endtask

	task automatic t_ctrl();
		apb(t16_pkg::IDX_CTRL_B, 1'b1, 8'hff);
		apb(t16_pkg::IDX_CTRL_B, 1'b0, 8'h00);
		chk("ctrl_b read", 32'hcf, q);
		apb(t16_pkg::IDX_CTRL_B, 1'b1, 8'h00);
		apb(t16_pkg::IDX_CTRL_A, 1'b1, 8'hff);
		apb(t16_pkg::IDX_CTRL_A, 1'b0, 8'h00);
		chk("ctrl_a read", 32'hf3, q);
		apb(t16_pkg::IDX_CTRL_A, 1'b1, 8'h00);
	endtask

	// Forced actions, mode changed alongside the force
	task automatic t_force();
		logic [7:0] fd [7] = '{8'hc0, 8'hc8, 8'h88, 8'h88,
			8'h48, 8'h48, 8'h48};
		logic [6:0] fe = 7'b0100110;
		logic       p;
		for (int i = 0; i < 7; i++)
		begin
			apb(t16_pkg::IDX_CTRL_A, 1'b1, fd[i]);
			chk("pin_a forced", {31'h0, fe[i]}, {31'h0, pin_a});
		end
		apb(t16_pkg::IDX_CTRL_A, 1'b1, 8'h34);
		chk("pin_b old mode", 32'h0, {31'h0, pin_b});
		apb(t16_pkg::IDX_CTRL_A, 1'b1, 8'h34);
		chk("pin_b forced", 32'h1, {31'h0, pin_b});
		apb(t16_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		chk("no force flag", 32'h0, q);
		apb(t16_pkg::IDX_CTRL_A, 1'b0, 8'h00);
		chk("force reads 0", 32'h30, q);
		apb(t16_pkg::IDX_CTRL_A, 1'b1, 8'hc1);
		p = pin_a;
		apb(t16_pkg::IDX_CTRL_A, 1'b1, 8'hc9);
		chk("force in pwm", {31'h0, p}, {31'h0, pin_a});
		apb(t16_pkg::IDX_CTRL_A, 1'b1, 8'h00);
	endtask

	task automatic t_temp();
		logic [15:0] v;
		wr16(t16_pkg::IDX_CNT_LO, 16'h1234);
		rd16(t16_pkg::IDX_CNT_LO, v);
		chk("counter word", 32'h1234, {16'h0, v});
		apb(t16_pkg::IDX_CMPA_HI, 1'b1, 8'hab);
		apb(t16_pkg::IDX_CNT_LO, 1'b1, 8'hcd);
		rd16(t16_pkg::IDX_CNT_LO, v);
		chk("shared temp", 32'habcd, {16'h0, v});
	endtask

	// Clear on compare A at 5 with toggle, every internal divider
	task automatic t_ctc();
		int x;
		int a;
		int b;
		wr16(t16_pkg::IDX_CNT_LO, 16'h0000);
		wr16(t16_pkg::IDX_CMPA_LO, 16'h0005);
		apb(t16_pkg::IDX_CTRL_A, 1'b1, 8'h40);
		for (int i = 0; i < 5; i++)
		begin
			apb(t16_pkg::IDX_CTRL_B, 1'b1, 8'h08 | 8'(i + 1));
			meas(x);
			meas(a);
			meas(b);
			chk("toggle period", 32'(12 * DIV[i]), 32'(a + b));
		end
		apb(t16_pkg::IDX_CTRL_B, 1'b1, 8'h00);
		apb(t16_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		chk("cmp a flag only", 32'h2, q & 32'h3);
		apb(t16_pkg::IDX_IRQ_STAT, 1'b1, 8'h0f);
	endtask

	// External edges of each polarity: six per toggle
	task automatic t_ext();
		logic p;
		for (int s = 6; s < 8; s++)
		begin
			apb(t16_pkg::IDX_CTRL_B, 1'b1, 8'h08 | 8'(s));
			wr16(t16_pkg::IDX_CNT_LO, 16'h0000);
			p = pin_a;
			repeat (5) pulse(4, 1'b1);
			chk("ext five", {31'h0, p}, {31'h0, pin_a});
			pulse(4, 1'b1);
			chk("ext six", {31'h0, ~p}, {31'h0, pin_a});
		end
		apb(t16_pkg::IDX_CTRL_B, 1'b1, 8'h00);
	endtask

	// Capture edges, filter, then the interrupt path
	task automatic t_cap();
		logic [15:0] v;
		wr16(t16_pkg::IDX_CNT_LO, 16'h0abc);
		apb(t16_pkg::IDX_CTRL_B, 1'b1, 8'h40);
		pulse(2, 1'b0);
		rd16(t16_pkg::IDX_CAP_LO, v);
		chk("capture rise", 32'h0abc, {16'h0, v});
		wr16(t16_pkg::IDX_CNT_LO, 16'h0123);
		apb(t16_pkg::IDX_CTRL_B, 1'b1, 8'hc0);
		pulse(2, 1'b0);
		rd16(t16_pkg::IDX_CAP_LO, v);
		chk("capture filtered", 32'h0abc, {16'h0, v});
		pulse(8, 1'b0);
		rd16(t16_pkg::IDX_CAP_LO, v);
		chk("capture passed", 32'h0123, {16'h0, v});
		apb(t16_pkg::IDX_CTRL_B, 1'b1, 8'h00);
		wr16(t16_pkg::IDX_CNT_LO, 16'h0055);
		pulse(6, 1'b0);
		rd16(t16_pkg::IDX_CAP_LO, v);
		chk("capture fall", 32'h0055, {16'h0, v});
		apb(t16_pkg::IDX_IRQ_MASK, 1'b1, 8'h08);
		chk("irq no global", 32'h0, {31'h0, irq});
		apb(t16_pkg::IDX_IRQ_GLOB, 1'b1, 8'h01);
		chk("irq on", 32'h1, {31'h0, irq});
		apb(t16_pkg::IDX_IRQ_MASK, 1'b1, 8'h00);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(t16_pkg::IDX_IRQ_MASK, 1'b1, 8'h08);
		apb(t16_pkg::IDX_IRQ_STAT, 1'b1, 8'h08);
		chk("irq cleared", 32'h0, {31'h0, irq});
		apb(t16_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		chk("status cleared", 32'h6, q);
	endtask

	// Pwm widths and count styles, read as pin A period
	task automatic t_pwm();
		logic [7:0] pm [5] = '{8'h81, 8'h82, 8'h83, 8'h81, 8'hc1};
		logic [7:0] cb [5] = '{8'h09, 8'h09, 8'h09, 8'h01, 8'h01};
		int         per [5] = '{256, 512, 1024, 510, 510};
		int         x;
		int         a;
		int         b;
		wr16(t16_pkg::IDX_CMPA_LO, 16'h0010);
		for (int i = 0; i < 5; i++)
		begin
			apb(t16_pkg::IDX_CTRL_B, 1'b1, 8'h00);
			wr16(t16_pkg::IDX_CNT_LO, 16'h0000);
			apb(t16_pkg::IDX_CTRL_A, 1'b1, pm[i]);
			apb(t16_pkg::IDX_CTRL_B, 1'b1, cb[i]);
			meas(x);
			meas(a);
			meas(b);
			chk("pwm period", 32'(per[i]), 32'(a + b));
		end
		apb(t16_pkg::IDX_IRQ_STAT, 1'b0, 8'h00);
		chk("overflow flag", 32'h1, q & 32'h1);
	endtask

	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_ctrl();
		t_force();
		t_temp();
		t_ctc();
		t_ext();
		t_cap();
		t_pwm();
		tally_and_finish();
	end
endmodule
